// ===== verilog/fprc_top.sv
// Pass/fail result word builder for one flash programming call.
// Assumes the flash array engine reports erase state and completion.
// What this block does, and what software does (RULE_06, RULE_07)
// RULE_01: Bits seven and three always read zero.
// RULE_02: Mode error when pin low or protected.
// RULE_03: No programming when pin low or protected.
// RULE_04: Execution error when target not erased and no other error is set.
// RULE_05: User boot area selected: fail, write nothing.
// RULE_06: Software erases area after execution error.
// RULE_07: Software programs boot area only elsewhere.
// RULE_08: Key error unless key equals 5A.
// RULE_09: Source error when source lies in flash.
// RULE_10: Destination error when outside flash.
// RULE_11: Destination error unless 128-byte aligned.
// RULE_12: Bit zero reports overall pass or fail.
// RULE_13: Result delivered to CPU low byte.
// RULE_14: Destination from 32-bit parameter register.
// RULE_15: Source in flash reported as error.
// RULE_16: Fail bit set when any error set.
`timescale 1ns/1ps
`include "fprc_defs.svh"
module fprc_top
    import fprc_pkg::*;
(
    // Clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RST_N,
    // Call parameters
    input  wire logic        START,
    input  wire logic [31:0] DEST_START_PARAM,
    input  wire logic [31:0] SOURCE_START_PARAM,
    input  wire fprc_byte_t  PROGRAM_KEY,
    input  wire fprc_byte_t  AREA_SELECT,
    // Flash state
    input  wire logic        WRITE_ENABLE_PIN,
    input  wire logic        ERROR_PROTECT_FLAG,
    input  wire logic        TARGET_ERASED,
    input  wire logic        WRITE_DONE,
    // Array control
    output logic             WRITE_GO,
    // Result
    output fprc_byte_t       CPU_RESULT_LOW_BYTE,
    output logic             DONE
);
    logic        pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_reg;
    fprc_state_t state_reg, state_next;
    fprc_byte_t  result_reg, result_next;
    logic        done_reg, go_reg;
    logic        mode_err, key_err, src_err, dest_err, boot_sel;

    // ==========================================================
    // Pin synchroniser
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            pin_s1_reg <= 1'b0;
            pin_s2_reg <= 1'b0;
            pin_s3_reg <= 1'b0;
            pin_reg    <= 1'b0;
        end else begin
            pin_s1_reg <= WRITE_ENABLE_PIN;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            if (pin_s2_reg == pin_s3_reg) begin
                pin_reg <= pin_s3_reg;
            end
        end
    end

    // ==========================================================
    // Checks
    fprc_check u_check (
        .dest_addr (DEST_START_PARAM),
        .src_addr  (SOURCE_START_PARAM),
        .key       (PROGRAM_KEY),
        .area      (AREA_SELECT),
        .wen_ok    (pin_reg),
        .protect   (ERROR_PROTECT_FLAG),
        .mode_err  (mode_err),
        .key_err   (key_err),
        .src_err   (src_err),
        .dest_err  (dest_err),
        .boot_sel  (boot_sel)
    );

    wire pre_err  = mode_err || key_err || src_err || dest_err;
    wire exec_pre = boot_sel || !TARGET_ERASED;               // RULE_04 RULE_05
    wire may_go   = !pre_err && !exec_pre;                    // RULE_03 RULE_05

    // ==========================================================
    // Sequencer
    always_comb begin
        state_next  = state_reg;
        result_next = result_reg;
        case (state_reg)
            FPRC_IDLE: begin
                if (START) begin
                    result_next = `FPRC_RESULT_RESET;
                    result_next[`FPRC_BIT_MODE_ERR] = mode_err;   // RULE_02
                    result_next[`FPRC_BIT_KEY_ERR]  = key_err;    // RULE_08
                    result_next[`FPRC_BIT_SRC_ERR]  = src_err;    // RULE_09
                    result_next[`FPRC_BIT_DEST_ERR] = dest_err;   // RULE_10 RULE_14
                    if (!pre_err && exec_pre) begin
                        result_next[`FPRC_BIT_EXEC_ERR] = 1'b1;   // RULE_04 RULE_05
                    end
                    result_next[`FPRC_BIT_FAIL] = pre_err || exec_pre; // RULE_12 RULE_16
                    state_next = may_go ? FPRC_WRITE : FPRC_DONE;
                end
            end
            FPRC_WRITE: begin
                if (WRITE_DONE) begin
                    state_next = FPRC_DONE;
                end
            end
            FPRC_DONE: begin
                state_next = FPRC_IDLE;
            end
            default: begin
                state_next = FPRC_IDLE;
            end
        endcase
        result_next[`FPRC_BIT_UNUSED_HI] = 1'b0;                  // RULE_01
        result_next[`FPRC_BIT_UNUSED_LO] = 1'b0;                  // RULE_01
    end

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg  <= FPRC_IDLE;
            result_reg <= `FPRC_RESULT_RESET;
            done_reg   <= 1'b0;
            go_reg     <= 1'b0;
        end else begin
            state_reg  <= state_next;
            result_reg <= result_next;
            done_reg   <= (state_next == FPRC_DONE);
            go_reg     <= (state_next == FPRC_WRITE);
        end
    end

    assign WRITE_GO            = go_reg;                         // RULE_03
    assign CPU_RESULT_LOW_BYTE = result_reg;                     // RULE_13
    assign DONE                = done_reg;
endmodule // fprc_top

// ===== common/fprc_defs.svh
// Constants for the flash program result check block.
// Assumes inclusion by bare name from design files.
`ifndef FPRC_DEFS_SVH
`define FPRC_DEFS_SVH
`define FPRC_BIT_UNUSED_HI   7
`define FPRC_BIT_MODE_ERR    6
`define FPRC_BIT_EXEC_ERR    5
`define FPRC_BIT_KEY_ERR     4
`define FPRC_BIT_UNUSED_LO   3
`define FPRC_BIT_SRC_ERR     2
`define FPRC_BIT_DEST_ERR    1
`define FPRC_BIT_FAIL        0
`define FPRC_KEY_GOOD        8'h5A
`define FPRC_AREA_USER_BOOT  8'hAA
`define FPRC_ALIGN_LO        8'h00
`define FPRC_ALIGN_HI        8'h80
`define FPRC_RESULT_RESET    8'h00
`define FPRC_FLASH_BASE      32'h00000000
`define FPRC_FLASH_LIMIT     32'h0001FFFF
`endif

// ===== common/fprc_pkg.sv
// Types for the flash program result check block.
// Assumes nothing beyond a SystemVerilog compiler.
package fprc_pkg;
    typedef enum logic [1:0] {FPRC_IDLE, FPRC_WRITE, FPRC_DONE} fprc_state_t;
    typedef logic [7:0] fprc_byte_t;
endpackage

// ===== verilog/fprc_check.sv
// Combinational pre-start checks of the programming parameters.
// Assumes synchronised inputs on the same clock as the caller.
`timescale 1ns/1ps
`include "fprc_defs.svh"
module fprc_check
    import fprc_pkg::*;
(
    // Parameters
    input  wire logic [31:0] dest_addr,
    input  wire logic [31:0] src_addr,
    input  wire fprc_byte_t  key,
    input  wire fprc_byte_t  area,
    // Protection state
    input  wire logic        wen_ok,
    input  wire logic        protect,
    // Results
    output logic             mode_err,
    output logic             key_err,
    output logic             src_err,
    output logic             dest_err,
    output logic             boot_sel
);
    function automatic logic in_flash(input logic [31:0] a);
        in_flash = (a >= `FPRC_FLASH_BASE) && (a <= `FPRC_FLASH_LIMIT);
    endfunction

    wire aligned = (dest_addr[7:0] == `FPRC_ALIGN_LO) || (dest_addr[7:0] == `FPRC_ALIGN_HI);

    assign mode_err = !wen_ok || protect;                   // RULE_02
    assign key_err  = (key != `FPRC_KEY_GOOD);              // RULE_08
    assign src_err  = in_flash(src_addr);                   // RULE_09 RULE_15
    assign dest_err = !in_flash(dest_addr) || !aligned;     // RULE_10 RULE_11 RULE_14
    assign boot_sel = (area == `FPRC_AREA_USER_BOOT);       // RULE_05
endmodule // fprc_check

// ===== testbench/fprc_top_assertions.sv
// Checker for the result word of fprc_top.
// Assumes binding to fprc_top; sees only its ports.
`timescale 1ns/1ps
module fprc_top_chk
    import fprc_pkg::*;
(
    // Clock, reset, call
    input wire logic        CLOCK,
    input wire logic        RST_N,
    input wire logic        START,
    input wire logic [31:0] DEST_START_PARAM,
    input wire logic [31:0] SOURCE_START_PARAM,
    input wire fprc_byte_t  PROGRAM_KEY,
    input wire fprc_byte_t  AREA_SELECT,
    // Flash state and outputs
    input wire logic        WRITE_ENABLE_PIN,
    input wire logic        ERROR_PROTECT_FLAG,
    input wire logic        TARGET_ERASED,
    input wire logic        WRITE_DONE,
    input wire logic        WRITE_GO,
    input wire fprc_byte_t  CPU_RESULT_LOW_BYTE,
    input wire logic        DONE
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    wire fprc_byte_t r = CPU_RESULT_LOW_BYTE;
    sequence s_take;
        START && !WRITE_GO && !DONE;
    endsequence
    a_unused_zero: assert property (!r[7] && !r[3]) else $error("unused bit set");
    a_fail_summary: assert property (DONE |-> r[0] == |r[6:1]) else $error("bad fail bit");
    a_key_check: assert property (s_take |=> r[4] == ($past(PROGRAM_KEY) != 8'h5A))
        else $error("bad key bit");
    a_src_check: assert property (s_take |=> r[2] == ($past(SOURCE_START_PARAM) <= 32'h1FFFF))
        else $error("bad source bit");
    a_dest_check: assert property (s_take |=> r[1] == ($past(DEST_START_PARAM) > 32'h1FFFF
        || $past(DEST_START_PARAM[6:0]) != 7'h00)) else $error("bad dest bit");
    a_mode_protect: assert property ((s_take and ERROR_PROTECT_FLAG) |=> r[6])
        else $error("no mode error");
    a_no_write: assert property (|r |-> !WRITE_GO) else $error("write after error");
    a_boot_refused: assert property ((s_take and (AREA_SELECT == 8'hAA)) |=> r[0] && !WRITE_GO)
        else $error("boot area written");
    a_exec_unerased: assert property ((s_take and !TARGET_ERASED)
        |=> r[5] == !(r[6] | r[4] | r[2] | r[1]))
        else $error("bad exec bit");
    a_error_answer: assert property (s_take |=> DONE == r[0]) else $error("bad error answer");
    a_write_end: assert property (WRITE_GO && WRITE_DONE |=> !WRITE_GO && DONE && r == 8'h00)
        else $error("bad write end");
endmodule // fprc_top_chk
bind fprc_top fprc_top_chk u_fprc_top_chk (.*);

// ===== testbench/fprc_top_tb_top.sv
// Testbench for fprc_top: programming calls with expected result words.
// Assumes the checker file is compiled alongside.
`timescale 1ns/1ps
`define CHK(nm, got, exp) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
module fprc_top_tb_top;
    import fprc_pkg::*;
    logic clock = 0, rst_n = 0, start = 0, pin = 1, prot = 0, erased = 1, wdone = 0, go;
    logic [31:0] dst = 0, src = 0;
    fprc_byte_t key = 0, area = 0, res;
    logic wgo, done;
    int num_errors = 0, comparisons = 0;
    always #12.5 clock = ~clock;
    fprc_top u_fprc_top (.CLOCK(clock), .RST_N(rst_n), .START(start), .DEST_START_PARAM(dst),
        .SOURCE_START_PARAM(src), .PROGRAM_KEY(key), .AREA_SELECT(area), .WRITE_ENABLE_PIN(pin),
        .ERROR_PROTECT_FLAG(prot), .TARGET_ERASED(erased), .WRITE_DONE(wdone), .WRITE_GO(wgo),
        .CPU_RESULT_LOW_BYTE(res), .DONE(done));
    task automatic stop_test;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic run(input logic [31:0] d, input fprc_byte_t k, a, input logic e,
                       input fprc_byte_t x, input logic [31:0] s = 32'h00FF0000);
        int n;
        @(posedge clock) #1;
        dst = d; src = s; key = k; area = a; erased = e; start = 1; go = 0;
        @(posedge clock) #1 start = 0;
        for (n = 0; n < 20 && done !== 1'b1; n++) begin
            go |= (wgo === 1'b1);
            wdone = (wgo === 1'b1) && n > 3;
            @(posedge clock) #1;
        end
        wdone = 0;
        if (n == 20) begin num_errors++; stop_test(); end
        `CHK("result", res, x)
        `CHK("write", go, (x == 8'h00))
    endtask
    initial begin
        repeat (10) @(posedge clock);
        #1 rst_n = 1;
        repeat (6) @(posedge clock);
        run(32'h1000, 8'h5A, 8'h00, 1, 8'h00);
        run(32'h1000, 8'h11, 8'h00, 1, 8'h11);
        run(32'h1000, 8'h5A, 8'h00, 1, 8'h05, 32'h1FFFF);
        run(32'h20000, 8'h5A, 8'h00, 1, 8'h03);
        run(32'h1080, 8'h5A, 8'h00, 1, 8'h00);
        run(32'h1040, 8'h5A, 8'h00, 1, 8'h03);
        run(32'h1000, 8'h5A, 8'hAA, 1, 8'h21);
        run(32'h1000, 8'h5A, 8'h00, 0, 8'h21);
        run(32'h1000, 8'h22, 8'h00, 0, 8'h11);
        run(32'h1000, 8'h5A, 8'h00, 1, 8'h00);
        prot = 1;
        run(32'h1000, 8'h5A, 8'h00, 1, 8'h41);
        prot = 0;
        pin = 0;
        repeat (8) @(posedge clock);
        run(32'h1000, 8'h5A, 8'h00, 1, 8'h41);
        run(32'h1000, 8'h00, 8'h00, 1, 8'h51);
        stop_test();
    end
endmodule // fprc_top_tb_top
